// file: shared/fps_regs.svh
// Constants of the host-side flash command sequencer: APB register map,
// field positions, command codes and pin timing counts.
// Assumes a 50 MHz sys_clk; every count below is derived from that period.
// Functional notes
// - Program is two unlock writes, set-up command, then address with data; width pin.
// - Hardware reset aborts at once; host reissues the whole sequence afterwards.
// - Bypass mode entry is two unlock writes then a write of 20h.
// - Bypass program is A0h then address with data, repeated freely.
// - Bypass exit is 90h then 00h, addresses ignored; back to array read.
// - Chip erase is six writes ending with the chip erase command.
// - Sector erase is six writes, last one sector address with erase command.
// - Host spaces extra sector erase writes less than 50 us apart.
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// APB register offsets.
`define FPS_REG_CTRL    8'h00
`define FPS_REG_ADDR    8'h04
`define FPS_REG_DATA    8'h08
`define FPS_REG_STATUS  8'h0c
`define FPS_REG_SECTOR  8'h10
`define FPS_REG_RDDATA  8'h14

// Control register fields.
`define FPS_CTRL_START  4
`define FPS_CTRL_ABORT  5
`define FPS_CTRL_BYTE   8

// Status register fields.
`define FPS_ST_BUSY     0
`define FPS_ST_BYPASS   1
`define FPS_ST_DONE     2
`define FPS_ST_ERR      3
`define FPS_ST_REFUSED  4
`define FPS_ST_RDYBSY   5

// Command data and unlock addresses.
`define FPS_D_UNLOCK1   8'haa
`define FPS_D_UNLOCK2   8'h55
`define FPS_D_PROG      8'ha0
`define FPS_D_BYP_ENTER 8'h20
`define FPS_D_BYP_EXIT1 8'h90
`define FPS_D_BYP_EXIT2 8'h00
`define FPS_D_ERASE     8'h80
`define FPS_D_CHIP      8'h10
`define FPS_D_SECTOR    8'h30
`define FPS_D_RESET     8'hf0
`define FPS_A1_WORD     20'h00555
`define FPS_A2_WORD     20'h002aa
`define FPS_A1_BYTE     20'h00aaa
`define FPS_A2_BYTE     20'h00555
`define FPS_SECT_DEPTH  4'h8

// Timing in ns or us and derived cycle counts.
`define FPS_CLK_NS      20
`define FPS_T_WP_NS     35
`define FPS_T_WPH_NS    30
`define FPS_T_RC_NS     70
`define FPS_T_RP_NS     500
`define FPS_T_RH_NS     50
`define FPS_T_WIN_US    50
`define FPS_WP_CYC      ((`FPS_T_WP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_WPH_CYC     ((`FPS_T_WPH_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RC_CYC      ((`FPS_T_RC_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RP_CYC      ((`FPS_T_RP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RH_CYC      ((`FPS_T_RH_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_WIN_CYC     ((`FPS_T_WIN_US * 1000) / `FPS_CLK_NS)

`endif

// file: shared/fps_pkg.sv
// Types of the host-side flash command sequencer.
// Assumes the constants of fps_regs.svh for all numeric values.
package fps_pkg;

	typedef enum logic [2:0] {
		OP_READ      = 3'b000,
		OP_PROG      = 3'b001,
		OP_BYP_ENTER = 3'b010,
		OP_BYP_PROG  = 3'b011,
		OP_BYP_EXIT  = 3'b100,
		OP_CHIP      = 3'b101,
		OP_SECT      = 3'b110,
		OP_RESET     = 3'b111
	} fps_op_e;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_WSET  = 3'b001,
		S_WLOW  = 3'b010,
		S_WHIGH = 3'b011,
		S_RLOW  = 3'b100,
		S_RCHK  = 3'b101,
		S_RST   = 3'b110,
		S_RREC  = 3'b111
	} fps_state_e;

endpackage : fps_pkg

// file: logic/fps_sector_mem.sv
// Small list of sector addresses queued for one sector erase sequence.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/1ns
module fps_sector_mem (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        wrEn,
	input  wire logic [2:0]  wrIdx,
	input  wire logic [19:0] wrData,
	input  wire logic [2:0]  rdIdx,
	output logic      [19:0] rdData
);

	logic [19:0] mem [0:7];
	logic [19:0] next_rdData;

	always_comb begin
		next_rdData = mem[rdIdx];
	end

	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrIdx] <= wrData;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= 20'h00000;
		end else begin
			rdData <= next_rdData;
		end
	end

endmodule : fps_sector_mem

// file: logic/fps_host.sv
// Host-side command sequencer for a parallel NOR flash, driven over APB.
// Assumes the flash pins are synchronous to sys_clk and the data bus is
// resolved outside from flashDqOut and flashDqOe.
`timescale 1ns/1ns
`include "fps_regs.svh"
module fps_host (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [19:0] flashAddr,
	output logic      [15:0] flashDqOut,
	output logic             flashDqOe,
	input  wire logic [15:0] flashDqIn,
	output logic             flashCeN,
	output logic             flashWeN,
	output logic             flashOeN,
	output logic             flashByteN,
	output logic             flashResetN,
	input  wire logic        readyBusyN
);

	localparam int WinCyc = `FPS_WIN_CYC;

	fps_pkg::fps_state_e state,     next_state;
	fps_pkg::fps_op_e    opReg,     next_opReg;
	logic [7:0]          timer,     next_timer;
	logic [3:0]          stepCnt,   next_stepCnt;
	logic [3:0]          sectCnt,   next_sectCnt;
	logic                byteMode,  next_byteMode;
	logic [19:0]         addrReg,   next_addrReg;
	logic [15:0]         dataReg,   next_dataReg;
	logic                bypass,    next_bypass;
	logic                done,      next_done;
	logic                err,       next_err;
	logic                refused,   next_refused;
	logic                pollFirst, next_pollFirst;
	logic                tlSeen,    next_tlSeen;
	logic [7:0]          pollPrev,  next_pollPrev;
	logic [15:0]         rdData,    next_rdData;
	logic [19:0]         next_flashAddr;
	logic [15:0]         next_flashDqOut;
	logic                next_flashDqOe, next_flashCeN, next_flashWeN;
	logic                next_flashOeN, next_flashResetN;
	logic [31:0]         next_prdata;
	logic                next_pready, next_pslverr;
	logic [19:0]         cmdAddr, a1, a2, sectAddr;
	logic [7:0]          cmdData;
	logic [3:0]          seqLen;
	logic                isPoll, apbWr, sectWr;
	fps_pkg::fps_op_e    reqOp;

	// ****************************************************************
	// Command table: address and data of each write in a sequence.
	// ****************************************************************
	fps_sector_mem u_sect (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.wrEn    (sectWr),
		.wrIdx   (sectCnt[2:0]),
		.wrData  (pwdata[19:0]),
		.rdIdx   (3'(next_stepCnt - 4'h5)),
		.rdData  (sectAddr)
	);

	always_comb begin
		a1 = byteMode ? `FPS_A1_BYTE : `FPS_A1_WORD;
		a2 = byteMode ? `FPS_A2_BYTE : `FPS_A2_WORD;
		cmdAddr = a1;
		cmdData = `FPS_D_UNLOCK1;
		case (stepCnt)
			4'h0: cmdData = `FPS_D_UNLOCK1;
			4'h1: begin
				cmdAddr = a2;
				cmdData = `FPS_D_UNLOCK2;
			end
			4'h2: cmdData = (opReg == fps_pkg::OP_PROG) ? `FPS_D_PROG :
				(opReg == fps_pkg::OP_BYP_ENTER) ? `FPS_D_BYP_ENTER : `FPS_D_ERASE;
			4'h3: begin
				cmdAddr = (opReg == fps_pkg::OP_PROG) ? addrReg : a1;
				cmdData = (opReg == fps_pkg::OP_PROG) ? dataReg[7:0] : `FPS_D_UNLOCK1;
			end
			4'h4: begin
				cmdAddr = a2;
				cmdData = `FPS_D_UNLOCK2;
			end
			default: begin
				cmdAddr = (opReg == fps_pkg::OP_SECT) ? sectAddr : a1;
				cmdData = (opReg == fps_pkg::OP_SECT) ? `FPS_D_SECTOR : `FPS_D_CHIP;
			end
		endcase
		case (opReg)
			fps_pkg::OP_BYP_PROG: begin
				cmdAddr = (stepCnt == 4'h0) ? a1 : addrReg;
				cmdData = (stepCnt == 4'h0) ? `FPS_D_PROG : dataReg[7:0];
			end
			fps_pkg::OP_BYP_EXIT: cmdData = (stepCnt == 4'h0) ? `FPS_D_BYP_EXIT1 :
				`FPS_D_BYP_EXIT2;
			fps_pkg::OP_RESET: cmdData = `FPS_D_RESET;
			default: cmdData = cmdData;
		endcase
		case (opReg)
			fps_pkg::OP_PROG:      seqLen = 4'h4;
			fps_pkg::OP_BYP_ENTER: seqLen = 4'h3;
			fps_pkg::OP_BYP_PROG:  seqLen = 4'h2;
			fps_pkg::OP_BYP_EXIT:  seqLen = 4'h2;
			fps_pkg::OP_CHIP:      seqLen = 4'h6;
			fps_pkg::OP_SECT:      seqLen = 4'h5 + sectCnt;
			fps_pkg::OP_RESET:     seqLen = 4'h1;
			default:               seqLen = 4'h0;
		endcase
		isPoll = (opReg == fps_pkg::OP_PROG) || (opReg == fps_pkg::OP_BYP_PROG) ||
			(opReg == fps_pkg::OP_CHIP) || (opReg == fps_pkg::OP_SECT);
	end

	// ****************************************************************
	// Sequencer and configuration state.
	// ****************************************************************
	always_comb begin
		next_state = state;
		next_opReg = opReg;
		next_timer = timer;
		next_stepCnt = stepCnt;
		next_sectCnt = sectCnt;
		next_byteMode = byteMode;
		next_addrReg = addrReg;
		next_dataReg = dataReg;
		next_bypass = bypass;
		next_done = done;
		next_err = err;
		next_refused = refused;
		next_pollFirst = pollFirst;
		next_tlSeen = tlSeen;
		next_pollPrev = pollPrev;
		next_rdData = rdData;
		next_flashAddr = flashAddr;
		next_flashDqOut = flashDqOut;
		next_flashDqOe = flashDqOe;
		next_flashCeN = flashCeN;
		next_flashWeN = flashWeN;
		next_flashOeN = flashOeN;
		next_flashResetN = flashResetN;
		apbWr = psel && penable && pready && pwrite;
		reqOp = fps_pkg::fps_op_e'(pwdata[2:0]);
		sectWr = 1'h0;
		case (state)
			fps_pkg::S_WSET: begin
				next_flashAddr = cmdAddr;
				next_flashDqOut = byteMode ? {8'h00, cmdData} :
					((opReg == fps_pkg::OP_PROG || opReg == fps_pkg::OP_BYP_PROG) &&
					stepCnt == seqLen - 4'h1) ?
					dataReg : {8'h00, cmdData};
				next_flashDqOe = 1'h1;
				next_flashCeN = 1'h0;
				next_state = fps_pkg::S_WLOW;
			end
			fps_pkg::S_WLOW: begin
				next_flashWeN = 1'h0;
				next_timer = 8'(`FPS_WP_CYC - 1);
				next_state = fps_pkg::S_WHIGH;
			end
			fps_pkg::S_WHIGH: begin
				if (timer != 8'h00) begin
					next_timer = timer - 8'h01;
				end else if (!flashWeN) begin
					next_flashWeN = 1'h1;
					next_timer = 8'(`FPS_WPH_CYC - 1);
				end else begin
					next_flashCeN = 1'h1;
					next_flashDqOe = 1'h0;
					next_stepCnt = stepCnt + 4'h1;
					if (stepCnt + 4'h1 != seqLen) begin
						next_state = fps_pkg::S_WSET;
					end else if (isPoll) begin
						next_flashAddr = addrReg;
						next_flashCeN = 1'h0;
						next_flashOeN = 1'h0;
						next_pollFirst = 1'h1;
						next_tlSeen = 1'h0;
						next_timer = 8'(`FPS_RC_CYC - 1);
						next_state = fps_pkg::S_RLOW;
					end else begin
						next_bypass = (opReg == fps_pkg::OP_BYP_ENTER) ||
							(bypass && opReg != fps_pkg::OP_BYP_EXIT);
						next_done = 1'h1;
						next_state = fps_pkg::S_IDLE;
					end
				end
			end
			fps_pkg::S_RLOW: begin
				if (timer != 8'h00) begin
					next_timer = timer - 8'h01;
				end else begin
					next_rdData = flashDqIn;
					next_flashOeN = 1'h1;
					next_flashCeN = 1'h1;
					next_state = fps_pkg::S_RCHK;
				end
			end
			fps_pkg::S_RCHK: begin
				if (opReg == fps_pkg::OP_READ || (!pollFirst && rdData[6] == pollPrev[6])) begin
					next_done = 1'h1;
					next_sectCnt = (opReg == fps_pkg::OP_SECT) ? 4'h0 : sectCnt;
					next_state = fps_pkg::S_IDLE;
				end else if (!pollFirst && tlSeen) begin
					next_err = 1'h1;
					next_done = 1'h1;
					next_state = fps_pkg::S_IDLE;
				end else begin
					next_tlSeen = !pollFirst && rdData[5];
					next_pollFirst = 1'h0;
					next_pollPrev = rdData[7:0];
					next_flashCeN = 1'h0;
					next_flashOeN = 1'h0;
					next_timer = 8'(`FPS_RC_CYC - 1);
					next_state = fps_pkg::S_RLOW;
				end
			end
			fps_pkg::S_RST: begin
				if (timer != 8'h00) begin
					next_timer = timer - 8'h01;
				end else begin
					next_flashResetN = 1'h1;
					next_timer = 8'(`FPS_RH_CYC - 1);
					next_state = fps_pkg::S_RREC;
				end
			end
			fps_pkg::S_RREC: begin
				if (timer != 8'h00) begin
					next_timer = timer - 8'h01;
				end else begin
					next_done = 1'h1;
					next_state = fps_pkg::S_IDLE;
				end
			end
			default: next_state = fps_pkg::S_IDLE;
		endcase
		if (apbWr) begin
			case (paddr)
				`FPS_REG_CTRL: begin
					if (pwdata[`FPS_CTRL_ABORT]) begin
						next_flashResetN = 1'h0;
						next_flashWeN = 1'h1;
						next_flashOeN = 1'h1;
						next_flashCeN = 1'h1;
						next_flashDqOe = 1'h0;
						next_bypass = 1'h0;
						next_done = 1'h0;
						next_timer = 8'(`FPS_RP_CYC - 1);
						next_state = fps_pkg::S_RST;
					end else if (pwdata[`FPS_CTRL_START]) begin
						if (state != fps_pkg::S_IDLE ||
							(bypass && (reqOp == fps_pkg::OP_PROG || reqOp == fps_pkg::OP_CHIP ||
							reqOp == fps_pkg::OP_SECT || reqOp == fps_pkg::OP_BYP_ENTER)) ||
							(!bypass && (reqOp == fps_pkg::OP_BYP_PROG ||
							reqOp == fps_pkg::OP_BYP_EXIT)) ||
							(reqOp == fps_pkg::OP_SECT && sectCnt == 4'h0)) begin
							next_refused = 1'h1;
						end else begin
							next_opReg = reqOp;
							next_byteMode = pwdata[`FPS_CTRL_BYTE];
							next_stepCnt = 4'h0;
							next_done = 1'h0;
							next_err = 1'h0;
							next_refused = 1'h0;
							next_flashAddr = addrReg;
							next_flashCeN = reqOp != fps_pkg::OP_READ;
							next_flashOeN = reqOp != fps_pkg::OP_READ;
							next_timer = 8'(`FPS_RC_CYC - 1);
							next_state = (reqOp == fps_pkg::OP_READ) ? fps_pkg::S_RLOW :
								fps_pkg::S_WSET;
						end
					end
				end
				`FPS_REG_ADDR: next_addrReg = (state == fps_pkg::S_IDLE) ? pwdata[19:0] : addrReg;
				`FPS_REG_DATA: next_dataReg = (state == fps_pkg::S_IDLE) ? pwdata[15:0] : dataReg;
				`FPS_REG_SECTOR: begin
					if (state == fps_pkg::S_IDLE && sectCnt != `FPS_SECT_DEPTH) begin
						sectWr = 1'h1;
						next_sectCnt = sectCnt + 4'h1;
					end else begin
						next_refused = 1'h1;
					end
				end
				default: next_refused = refused;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= fps_pkg::S_IDLE;
			opReg <= fps_pkg::OP_READ;
			timer <= 8'h00;
			stepCnt <= 4'h0;
			sectCnt <= 4'h0;
			byteMode <= 1'h0;
			addrReg <= 20'h00000;
			dataReg <= 16'h0000;
			bypass <= 1'h0;
			done <= 1'h0;
			err <= 1'h0;
			refused <= 1'h0;
			pollFirst <= 1'h0;
			tlSeen <= 1'h0;
			pollPrev <= 8'h00;
			rdData <= 16'h0000;
			flashAddr <= 20'h00000;
			flashDqOut <= 16'h0000;
			flashDqOe <= 1'h0;
			flashCeN <= 1'h1;
			flashWeN <= 1'h1;
			flashOeN <= 1'h1;
			flashByteN <= 1'h1;
			flashResetN <= 1'h1;
		end else begin
			state <= next_state;
			opReg <= next_opReg;
			timer <= next_timer;
			stepCnt <= next_stepCnt;
			sectCnt <= next_sectCnt;
			byteMode <= next_byteMode;
			addrReg <= next_addrReg;
			dataReg <= next_dataReg;
			bypass <= next_bypass;
			done <= next_done;
			err <= next_err;
			refused <= next_refused;
			pollFirst <= next_pollFirst;
			tlSeen <= next_tlSeen;
			pollPrev <= next_pollPrev;
			rdData <= next_rdData;
			flashAddr <= next_flashAddr;
			flashDqOut <= next_flashDqOut;
			flashDqOe <= next_flashDqOe;
			flashCeN <= next_flashCeN;
			flashWeN <= next_flashWeN;
			flashOeN <= next_flashOeN;
			flashByteN <= !next_byteMode;
			flashResetN <= next_flashResetN;
		end
	end

	// ****************************************************************
	// APB answer: one wait state, error on unmapped offsets.
	// ****************************************************************
	always_comb begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'h0;
		next_prdata = prdata;
		if (psel && penable && !pready) begin
			next_prdata = 32'h00000000;
			case (paddr)
				`FPS_REG_CTRL:   next_prdata = {23'h000000, byteMode, 5'h00, opReg};
				`FPS_REG_ADDR:   next_prdata = {12'h000, addrReg};
				`FPS_REG_DATA:   next_prdata = {16'h0000, dataReg};
				`FPS_REG_STATUS: next_prdata = {12'h000, sectCnt, pollPrev, 2'h0, readyBusyN,
					refused, err, done, bypass, state != fps_pkg::S_IDLE};
				`FPS_REG_SECTOR: next_prdata = {28'h0000000, sectCnt};
				`FPS_REG_RDDATA: next_prdata = {16'h0000, rdData};
				default:         next_pslverr = 1'h1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h00000000;
			pready <= 1'h0;
			pslverr <= 1'h0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Checks on the flash pins and on APB ready.
	// ****************************************************************
	logic [15:0] weGap;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			weGap <= 16'h0000;
		end else begin
			weGap <= $rose(flashWeN) ? 16'h0000 : weGap + 16'h0001;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	we_pulse_len_a: assert property ($fell(flashWeN) |=> !flashWeN ##1 flashWeN)
		else $error("write strobe low time wrong");
	wr_addr_hold_a: assert property (!flashWeN && $past(!flashWeN) |->
		$stable(flashAddr) && $stable(flashDqOut) && flashDqOe)
		else $error("address or data moved under write strobe");
	oe_we_excl_a: assert property (!(!flashOeN && !flashWeN))
		else $error("read and write strobes both active");
	unlock_first_a: assert property ($fell(flashWeN) && stepCnt == 4'h0 &&
		(opReg == fps_pkg::OP_PROG || opReg == fps_pkg::OP_CHIP ||
		opReg == fps_pkg::OP_SECT || opReg == fps_pkg::OP_BYP_ENTER) |->
		flashDqOut[7:0] == `FPS_D_UNLOCK1)
		else $error("sequence does not open with unlock");
	bypass_enter_a: assert property ($fell(flashWeN) && opReg == fps_pkg::OP_BYP_ENTER &&
		stepCnt == 4'h2 |-> flashDqOut[7:0] == 8'h20 ##6 bypass)
		else $error("bypass entry command wrong");
	bypass_prog_a: assert property ($fell(flashWeN) && opReg == fps_pkg::OP_BYP_PROG &&
		stepCnt == 4'h0 |-> flashDqOut[7:0] == 8'ha0)
		else $error("bypass program command wrong");
	bypass_exit_a: assert property ($fell(flashWeN) && opReg == fps_pkg::OP_BYP_EXIT |->
		flashDqOut[7:0] == ((stepCnt == 4'h0) ? 8'h90 : 8'h00))
		else $error("bypass exit data wrong");
	sector_cmd_a: assert property ($fell(flashWeN) && opReg == fps_pkg::OP_SECT &&
		stepCnt >= 4'h5 |-> flashDqOut[7:0] == 8'h30)
		else $error("sector erase command wrong");
	sector_gap_a: assert property ($fell(flashWeN) && opReg == fps_pkg::OP_SECT &&
		stepCnt > 4'h5 |-> weGap < 16'(WinCyc))
		else $error("extra sector write too late");
	reset_pulse_a: assert property ($fell(flashResetN) |-> !flashResetN[*8])
		else $error("hardware reset pulse too short");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("apb ready held two cycles");

endmodule : fps_host

// file: test/fps_flash_model.sv
// Behavioural NOR flash that answers the host sequencer's pins.
// Assumes pins change just after sys_clk edges; strobes are sampled on sys_clk.
`timescale 1ns/1ns
// ****
// Flash model
// ****
module fps_flash_model #(
	parameter int BUSY = 200,
	parameter int WIN  = 2500
) (
	input  wire logic        sys_clk,
	input  wire logic [19:0] flashAddr,
	input  wire logic [15:0] flashDqOut,
	input  wire logic        flashCeN,
	input  wire logic        flashWeN,
	input  wire logic        flashOeN,
	input  wire logic        flashByteN,
	input  wire logic        flashResetN,
	output logic      [15:0] flashDqIn,
	output logic             readyBusyN
);
	logic [15:0] mem [16];
	logic [15:0] last, pd, sts;
	logic [19:0] a;
	logic [3:0]  mask;
	logic        weOld, oeOld, byp, tog, chip, ok1, ok2;
	int          st, bc, win;
	initial begin
		foreach (mem[i]) mem[i] = 16'hffff;
		{last, pd, a, mask, byp, tog, chip, st, bc, win} = '0;
		{weOld, oeOld, readyBusyN} = 3'b111;
		flashDqIn = 16'h0000;
	end
	task pgm(input logic [15:0] d);
		mem[{a[17:16], a[1:0]}] &= flashByteN ? d : {8'hff, d[7:0]};
		pd = d;
		bc = BUSY;
	endtask : pgm
	task wr(input logic [15:0] d);
		ok1 = a[11:0] == (flashByteN ? 12'h555 : 12'haaa);
		ok2 = a[11:0] == (flashByteN ? 12'h2aa : 12'h555);
		if (bc > 0) return;
		if (win > 0) begin
			mask[a[17:16]] |= d[7:0] == 8'h30;
			win = d[7:0] == 8'h30 ? WIN : 0;
			mask = win > 0 ? mask : 4'h0;
		end else if (d[7:0] == 8'hf0) st = 0;
		else if (byp) begin
			byp = !(st == 3 && d[7:0] == 8'h00);
			if (st == 1) pgm(d);
			st = st == 0 && d[7:0] == 8'ha0 ? 1 : st == 0 && d[7:0] == 8'h90 ? 3 : 0;
		end else begin
			if (st == 3) pgm(d);
			byp = st == 2 && ok1 && d[7:0] == 8'h20;
			chip = st == 6 && ok1 && d[7:0] == 8'h10;
			bc = chip ? BUSY : bc;
			mask[a[17:16]] = st == 6 && d[7:0] == 8'h30;
			win = mask != 4'h0 ? WIN : 0;
			st = (st == 0 || st == 4) && ok1 && d[7:0] == 8'haa ? st + 1 :
				(st == 1 || st == 5) && ok2 && d[7:0] == 8'h55 ? st + 1 :
				st == 2 && ok1 && d[7:0] == 8'ha0 ? 3 : st == 2 && ok1 && d[7:0] == 8'h80 ? 4 : 0;
		end
	endtask : wr
	always @(posedge sys_clk) begin
		if (!flashResetN) begin
			{st, bc, win, byp, mask, chip} = '0;
		end else begin
			if (weOld && !flashWeN && !flashCeN) a = flashAddr;
			if (!weOld && flashWeN && !flashCeN) wr(flashDqOut);
			if (bc == 1) begin
				foreach (mem[i]) if (chip || mask[i / 4]) mem[i] = 16'hffff;
				{chip, mask} = '0;
			end
			bc = bc > 0 ? bc - 1 : 0;
			if (win == 1) bc = BUSY;
			win = win > 0 ? win - 1 : 0;
			if (oeOld && !flashOeN && !flashCeN) tog = ~tog;
		end
		weOld = flashWeN;
		oeOld = flashOeN;
		sts = {8'h00, ~pd[7], tog, 2'b00, bc > 0 && (chip || mask != 0), tog, 2'b00};
		if (!flashOeN && !flashCeN)
			last = bc > 0 || win > 0 ? sts : mem[{flashAddr[17:16], flashAddr[1:0]}];
		flashDqIn <= !flashOeN && !flashCeN ? last : ~last;
		readyBusyN <= !(bc > 0);
	end
endmodule : fps_flash_model

// file: test/fps_host_test.sv
// Self-checking bench for the host sequencer over APB against the flash model.
// Assumes the register map of fps_regs.svh.
`timescale 1ns/1ns
`include "fps_regs.svh"
// ****
// Testbench
// ****
module fps_host_test;
	logic        sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, flashDqOe, flashCeN, flashWeN, flashOeN;
	logic        flashByteN, flashResetN, readyBusyN, sawRst = 1'b0;
	logic [19:0] flashAddr;
	logic [15:0] flashDqOut, flashDqIn;
	int          failures = 0, n_compared = 0, cyc = 0;
	always #10 sys_clk = ~sys_clk;
	fps_host dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .flashCeN, .flashWeN,
		.flashOeN, .flashByteN, .flashResetN, .readyBusyN);
	fps_flash_model model (.sys_clk, .flashAddr, .flashDqOut, .flashCeN, .flashWeN, .flashOeN,
		.flashByteN, .flashResetN, .flashDqIn, .readyBusyN);
	task end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	always @(posedge sys_clk) begin
		cyc++;
		if (flashResetN === 1'b0) sawRst <= 1'b1;
		if (cyc == 90000) begin
			failures++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task op(input logic [31:0] c);
		apb(1'b1, `FPS_REG_CTRL, c | 32'h10);
		rd = 32'h0;
		for (int i = 0; i < 3000 && rd[`FPS_ST_DONE] !== 1'b1; i++) apb(1'b0, `FPS_REG_STATUS, 0);
		chk(rd[`FPS_ST_DONE], 1);
	endtask : op
	task prog(input logic [31:0] c, input logic [19:0] ad, input logic [15:0] d);
		apb(1'b1, `FPS_REG_ADDR, {12'h000, ad});
		apb(1'b1, `FPS_REG_DATA, {16'h0000, d});
		if (c != 0) op(c);
	endtask : prog
	task rdw(input logic [19:0] ad, input logic [15:0] e);
		prog(0, ad, 16'h0000);
		op(0);
		apb(1'b0, `FPS_REG_RDDATA, 0);
		chk({16'h0000, rd[15:0]}, {16'h0000, e});
	endtask : rdw
	task refuse(input logic [31:0] c);
		apb(1'b1, `FPS_REG_CTRL, c | 32'h10);
		apb(1'b0, `FPS_REG_STATUS, 0);
		chk(rd[`FPS_ST_REFUSED], 1);
	endtask : refuse
	task t_prog;
		prog(1, 20'h0ffff, 16'h1234);
		rdw(20'h0ffff, 16'h1234);
		prog(1, 20'h10000, 16'h00ff);
		rdw(20'h10000, 16'h00ff);
		prog(1, 20'h0ffff, 16'hffff);
		rdw(20'h0ffff, 16'h1234);
	endtask : t_prog
	task t_byp;
		op(2);
		chk(rd[`FPS_ST_BYPASS], 1);
		prog(3, 20'h00001, 16'h5a5a);
		prog(3, 20'h00002, 16'h0f0f);
		rdw(20'h00001, 16'h5a5a);
		rdw(20'h00002, 16'h0f0f);
		refuse(5);
		op(4);
		apb(1'b0, `FPS_REG_STATUS, 0);
		chk(rd[`FPS_ST_BYPASS], 0);
		refuse(3);
	endtask : t_byp
	task t_erase;
		prog(1, 20'h20002, 16'h0000);
		apb(1'b1, `FPS_REG_SECTOR, 32'h20000);
		apb(1'b1, `FPS_REG_SECTOR, 32'h30000);
		apb(1'b0, `FPS_REG_SECTOR, 0);
		chk(rd, 2);
		op(6);
		rdw(20'h20002, 16'hffff);
		rdw(20'h10000, 16'h00ff);
		op(5);
		rdw(20'h10000, 16'hffff);
		prog(32'h101, 20'h00003, 16'h005a);
		rdw(20'h00003, 16'hff5a);
	endtask : t_erase
	task t_abort;
		prog(0, 20'h00005, 16'h00aa);
		apb(1'b1, `FPS_REG_CTRL, 32'h11);
		repeat (60) @(posedge sys_clk);
		op(32'h20);
		chk({sawRst, rd[`FPS_ST_RDYBSY], rd[`FPS_ST_BUSY]}, 3'b110);
		op(7);
		prog(1, 20'h00005, 16'h00aa);
		rdw(20'h00005, 16'h00aa);
		apb(1'b0, 8'h20, 0);
		chk(err, 1);
	endtask : t_abort
	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		t_prog();
		t_byp();
		t_erase();
		t_abort();
		end_of_test();
	end
endmodule : fps_host_test
